// ### pkg/lfoc_consts.svh
// Constants for the low-frequency oscillator control block.
`ifndef LFOC_CONSTS_SVH
`define LFOC_CONSTS_SVH
// ****************************************************************
// Register map and fields
// ****************************************************************
`define LFOC_CTRL_ADDR     8'h86
`define LFOC_BIT_EN        7
`define LFOC_BIT_RDY       6
`define LFOC_TRIM_HI       5
`define LFOC_TRIM_LO       2
`define LFOC_DIV_HI        1
`define LFOC_DIV_LO        0
`define LFOC_DIV_RESET     2'h0
`define LFOC_TRIM_FACTORY  4'h8
// ****************************************************************
// Timing
// ****************************************************************
`define LFOC_CLK_HZ        10000000
`define LFOC_NOM_HZ        80000
`define LFOC_SETTLE_US     100
`define LFOC_SETTLE_CYC    ((`LFOC_SETTLE_US * (`LFOC_CLK_HZ / 1000000)))
`endif

// ### pkg/lfoc_osc_if.sv
// Interface between the control logic and the oscillator model core.
`timescale 1ns/1ps
interface lfoc_osc_if;
  logic                enable;
  lfoc_pkg::lfoc_trim_t trim;
  logic                osc_out;
  logic                stable;
  modport ctrl (output enable, output trim, input osc_out, input stable);
  modport core (input enable, input trim, output osc_out, output stable);
endinterface : lfoc_osc_if

// ### pkg/lfoc_pkg.sv
// Types shared by the low-frequency oscillator control block.
package lfoc_pkg;
  typedef enum logic [1:0] {
    LFOC_DIV8 = 2'h0,
    LFOC_DIV4 = 2'h1,
    LFOC_DIV2 = 2'h2,
    LFOC_DIV1 = 2'h3
  } lfoc_div_e;
  typedef logic [3:0] lfoc_trim_t;
endpackage : lfoc_pkg

// ### src/lfoc_osc_core.sv
// Digital stand-in for the oscillator: trimmed half-period counter and settle timer.
`timescale 1ns/1ps
`include "lfoc_consts.svh"
module lfoc_osc_core #(
  parameter int SETTLE_CYC = `LFOC_SETTLE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  lfoc_osc_if.core  osc
);
  // Nominal half period in system clocks at trim midpoint.
  localparam int HALF_NOM = `LFOC_CLK_HZ / (2 * `LFOC_NOM_HZ);
  logic [7:0]  half_cnt_r;
  logic [7:0]  half_len;
  logic        osc_r;
  logic [23:0] settle_r;
  logic        stable_r;

  // Larger trim gives a longer half period, so a slower oscillator.
  assign half_len = 8'(HALF_NOM - 8 + 32'(osc.trim));

  // Toggle only while enabled; a stopped oscillator holds low.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      half_cnt_r <= 8'h00;
      osc_r      <= 1'b0;
    end else if (!osc.enable) begin
      half_cnt_r <= 8'h00;
      osc_r      <= 1'b0;
    end else if (half_cnt_r >= half_len - 8'h01) begin
      half_cnt_r <= 8'h00;
      osc_r      <= ~osc_r;
    end else begin
      half_cnt_r <= half_cnt_r + 8'h01;
    end
  end

  // Stability is reported after a settle time of continuous running.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      settle_r <= 24'h000000;
      stable_r <= 1'b0;
    end else if (!osc.enable) begin
      settle_r <= 24'h000000;
      stable_r <= 1'b0;
    end else if (settle_r >= 24'(SETTLE_CYC)) begin
      stable_r <= 1'b1;
    end else begin
      settle_r <= settle_r + 24'h000001;
    end
  end

  assign osc.osc_out = osc_r;
  assign osc.stable  = stable_r;
endmodule : lfoc_osc_core

// ### src/lfoc_top.sv
// Low-frequency oscillator control register, output divider and timer capture path.
`timescale 1ns/1ps
`include "lfoc_consts.svh"
module lfoc_top #(
  parameter int SETTLE_CYC = `LFOC_SETTLE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic [3:0]  factory_trim,
  input  wire logic        t2_capture_mode,
  input  wire logic        t3_capture_mode,
  input  wire logic [15:0] t2_count,
  input  wire logic [15:0] t3_count,
  output logic      [15:0] t2_reload,
  output logic      [15:0] t3_reload,
  output logic             t2_capture,
  output logic             t3_capture,
  output logic             lfo_clk
);
  // ****************************************************************
  // Control register
  // ****************************************************************
  logic                  lfo_enable_r;
  logic                  lfo_ready_r;
  lfoc_pkg::lfoc_trim_t  lfo_trim_r;
  lfoc_pkg::lfoc_div_e   lfo_divider_select_r;
  logic                  trim_loaded_r;
  logic [23:0]           resettle_r;
  logic                  ctrl_wr;
  logic                  div_change;
  lfoc_osc_if            osc ();

  lfoc_osc_core #(.SETTLE_CYC(SETTLE_CYC)) u_core (
    .clk_sys (clk_sys),
    .reset   (reset),
    .osc     (osc.core)
  );

  // The register is decoded on address alone, so page selection never hides it.
  assign ctrl_wr    = sfr_wr && (sfr_addr == `LFOC_CTRL_ADDR);
  assign div_change = ctrl_wr && (sfr_wdata[`LFOC_DIV_HI:`LFOC_DIV_LO] != lfo_divider_select_r);

  // Enable and divider reset to zero; software writes them directly.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lfo_enable_r         <= 1'b0;
      lfo_divider_select_r <= lfoc_pkg::LFOC_DIV8;
    end else if (ctrl_wr) begin
      lfo_enable_r         <= sfr_wdata[`LFOC_BIT_EN];
      lfo_divider_select_r <= lfoc_pkg::lfoc_div_e'(sfr_wdata[`LFOC_DIV_HI:`LFOC_DIV_LO]);
    end
  end

  // Async reset may only load a constant, so the factory trim is taken on the first clock after release.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lfo_trim_r    <= `LFOC_TRIM_FACTORY;
      trim_loaded_r <= 1'b0;
    end else if (!trim_loaded_r) begin
      lfo_trim_r    <= factory_trim;
      trim_loaded_r <= 1'b1;
    end else if (ctrl_wr) begin
      // Writes while running are accepted; glitch-free retrim is firmware's duty.
      lfo_trim_r    <= sfr_wdata[`LFOC_TRIM_HI:`LFOC_TRIM_LO];
    end
  end

  // A divider change restarts a settle wait; without it the still-high stable level would re-set ready at once.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      resettle_r <= 24'h000000;
    end else if (div_change) begin
      resettle_r <= 24'(SETTLE_CYC);
    end else if (resettle_r != 24'h000000) begin
      resettle_r <= resettle_r - 24'h000001;
    end
  end

  // Ready is sticky: stable sets it, only reset or a divider change clears it.
  // A divider change in the same cycle as stability wins, since the output restarts.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lfo_ready_r <= 1'b0;
    end else if (div_change) begin
      lfo_ready_r <= 1'b0;
    end else if (osc.stable && resettle_r == 24'h000000) begin
      lfo_ready_r <= 1'b1;
    end
  end

  assign osc.enable = lfo_enable_r;
  assign osc.trim   = lfo_trim_r;

  // Registered read data; unmapped addresses read as zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == `LFOC_CTRL_ADDR) begin
      sfr_rdata <= {lfo_enable_r, lfo_ready_r, lfo_trim_r, lfo_divider_select_r};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Output divider
  // ****************************************************************
  logic [2:0] div_cnt_r;
  logic       osc_d_r;
  logic       osc_rise;

  // Divide by rising-edge counting; a stopped oscillator freezes the divider.
  function automatic logic div_tap(input lfoc_pkg::lfoc_div_e sel, input logic [2:0] cnt, input logic raw);
    unique case (sel)
      lfoc_pkg::LFOC_DIV8: div_tap = cnt[2];
      lfoc_pkg::LFOC_DIV4: div_tap = cnt[1];
      lfoc_pkg::LFOC_DIV2: div_tap = cnt[0];
      lfoc_pkg::LFOC_DIV1: div_tap = raw;
    endcase
  endfunction : div_tap

  assign osc_rise = osc.osc_out && !osc_d_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      osc_d_r   <= 1'b0;
      div_cnt_r <= 3'h0;
    end else begin
      osc_d_r <= osc.osc_out;
      if (div_change) begin
        div_cnt_r <= 3'h0;
      end else if (osc_rise) begin
        div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end

  // Registered output tap keeps the top output straight from a flip-flop.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lfo_clk <= 1'b0;
    end else begin
      lfo_clk <= div_tap(lfo_divider_select_r, div_cnt_r, osc.osc_out);
    end
  end

  // ****************************************************************
  // Calibration capture
  // ****************************************************************
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic cap_fall;
  logic cap_rise;

  // Three-stage synchroniser; only the second and third stages feed edge detection.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= lfo_clk;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Edge decode is shared by the pulse and the reload copy, so both always agree.
  assign cap_fall = t2_capture_mode && sync3_r && !sync2_r;
  assign cap_rise = t3_capture_mode && !sync3_r && sync2_r;

  // Timer 2 takes falling edges, timer 3 rising ones; the whole count is copied at once.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      t2_capture <= 1'b0;
      t3_capture <= 1'b0;
      t2_reload  <= 16'h0000;
      t3_reload  <= 16'h0000;
    end else begin
      t2_capture <= cap_fall;
      t3_capture <= cap_rise;
      if (cap_fall) begin
        t2_reload <= t2_count;
      end
      if (cap_rise) begin
        t3_reload <= t3_count;
      end
    end
  end
endmodule : lfoc_top

// ### testbench/lfoc_checker.sv
// Port checker for the oscillator control block.
`timescale 1ns/1ps
module lfoc_checker (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        t2_capture_mode,
  input wire logic        t3_capture_mode,
  input wire logic [15:0] t2_count,
  input wire logic [15:0] t3_count,
  input wire logic [15:0] t2_reload,
  input wire logic [15:0] t3_reload,
  input wire logic        t2_capture,
  input wire logic        t3_capture,
  input wire logic        lfo_clk
);
  logic [2:0] shadow_r;
  logic [2:0] off_r;
  // Enable and divider select as last written.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) shadow_r <= 3'h0;
    else if (sfr_wr && sfr_addr == 8'h86) shadow_r <= {sfr_wdata[7], sfr_wdata[1:0]};
  end
  // Cycles since enable dropped; saturates so the output pipeline can drain first.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) off_r <= 3'h0;
    else off_r <= shadow_r[2] ? 3'h0 : ((off_r == 3'h7) ? off_r : off_r + 3'h1);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_cap_fall: assert property ($fell(lfo_clk) && t2_capture_mode |-> ##[1:4] t2_capture)
    else $error("timer 2 capture missing");
  chk_cap_rise: assert property ($rose(lfo_clk) && t3_capture_mode |-> ##[1:4] t3_capture)
    else $error("timer 3 capture missing");
  chk_mode_gate: assert property (!t2_capture_mode && !t3_capture_mode |=> !t2_capture && !t3_capture)
    else $error("capture while mode off");
  chk_cap_single: assert property (t2_capture || t3_capture |=> !(t2_capture || t3_capture))
    else $error("capture pulse too long");
  chk_reload_copy: assert property (t2_capture |-> t2_reload == $past(t2_count))
    else $error("reload not copied");
  chk_reload_hold: assert property (!t3_capture |-> $stable(t3_reload))
    else $error("reload changed without capture");
  chk_osc_stopped: assert property (off_r == 3'h7 |-> $stable(lfo_clk))
    else $error("oscillator runs while disabled");
  chk_read_ctrl: assert property (sfr_rd && sfr_addr == 8'h86 |=>
    {sfr_rdata[7], sfr_rdata[1:0]} == $past(shadow_r))
    else $error("control read wrong");
  chk_read_zero: assert property (!(sfr_rd && sfr_addr == 8'h86) |=> sfr_rdata == 8'h00)
    else $error("read data not zero");
endmodule : lfoc_checker
bind lfoc_top lfoc_checker u_chk (.clk_sys, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .t2_capture_mode, .t3_capture_mode,
  .t2_count, .t3_count, .t2_reload, .t3_reload, .t2_capture, .t3_capture, .lfo_clk);

// ### testbench/lfoc_timer_model.sv
// Model of the two timers that count system clocks.
`timescale 1ns/1ps
module lfoc_timer_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  output logic      [15:0] t2_count,
  output logic      [15:0] t3_count
);
  // Both count up every clock; timer 3 starts near the top so it wraps early.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      t2_count <= 16'h0000;
      t3_count <= 16'hFFF0;
    end else begin
      t2_count <= t2_count + 16'h0001;
      t3_count <= t3_count + 16'h0001;
    end
  end
endmodule : lfoc_timer_model

// ### testbench/lfoc_top_test.sv
// Self-checking bench for the oscillator control block.
`timescale 1ns/1ps
module lfoc_top_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [7:0]  rd;
  logic [15:0] t2_count, t3_count, t2_reload, t3_reload;
  logic        t2_capture, t3_capture, lfo_clk;
  logic        t2_capture_mode = 1'b1;
  logic        t3_capture_mode = 1'b1;
  int          num_errors = 0;
  int          n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  lfoc_timer_model partner (.clk_sys, .reset, .t2_count, .t3_count);
  lfoc_top #(.SETTLE_CYC(20)) uut (.clk_sys, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .factory_trim(4'h5), .t2_capture_mode, .t3_capture_mode, .t2_count, .t3_count,
    .t2_reload, .t3_reload, .t2_capture, .t3_capture, .lfo_clk);
  // ****
  // Shared tasks
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Inputs always change 1 ns after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] d);
    sfr_addr = 8'h86;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    rd = sfr_rdata;
    sfr_rd = 1'b0;
    tick(1);
  endtask : rdr
  // Clocks until the next rising output edge; bounded so a dead output shows as a long period.
  task automatic edge_wait(output int n);
    logic last;
    n = 0;
    last = lfo_clk;
    while (!(lfo_clk && !last) && n < 3000) begin
      last = lfo_clk;
      tick(1);
      n++;
    end
  endtask : edge_wait
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    rdr(8'h86);
    check("ctrl after reset", {8'h00, rd}, 16'h0014);
    rdr(8'h87);
    check("unmapped read", {8'h00, rd}, 16'h0000);
  endtask : t_reset
  task automatic t_ready();
    wr(8'hE3);
    rdr(8'h86);
    check("ready before settle", {8'h00, rd}, 16'h00A3);
    tick(30);
    rdr(8'h86);
    check("ready after settle", {8'h00, rd}, 16'h00E3);
    wr(8'hA3);
    rdr(8'h86);
    check("ready same divider", {8'h00, rd}, 16'h00E3);
    wr(8'hA2);
    rdr(8'h86);
    check("ready new divider", {8'h00, rd}, 16'h00A2);
    tick(30);
    rdr(8'h86);
    check("ready after resettle", {8'h00, rd}, 16'h00E2);
  endtask : t_ready
  task automatic t_div();
    int p;
    logic [3:0] tr;
    logic [1:0] dv;
    for (int i = 0; i < 6; i++) begin
      tr = (i < 4) ? 4'h8 : ((i == 4) ? 4'h0 : 4'hF);
      dv = (i < 4) ? i[1:0] : 2'h3;
      wr(8'h00);
      wr({1'b1, 1'b0, tr, dv});
      edge_wait(p);
      edge_wait(p);
      check("output period", p[15:0], 16'(2 * (54 + int'(tr)) * (8 >> dv)));
    end
  endtask : t_div
  task automatic t_stop();
    int n;
    wr(8'h03);
    tick(10);
    n = 0;
    repeat (400) begin
      rd[0] = lfo_clk;
      tick(1);
      if (lfo_clk !== rd[0]) n++;
    end
    check("edges while off", n[15:0], 16'h0000);
  endtask : t_stop
  task automatic t_cap(input logic three);
    int n;
    logic [15:0] first;
    wr(8'hA3);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (!(three ? t3_capture : t2_capture) && n < 1000) begin
        tick(1);
        n++;
      end
      check("capture wait", {15'h0000, 1'(n < 1000)}, 16'h0001);
      check("level at capture", {15'h0000, lfo_clk}, {15'h0000, three});
      check("reload copy", three ? t3_reload : t2_reload, (three ? t3_count : t2_count) - 16'h0001);
      if (k == 0) first = three ? t3_reload : t2_reload;
      tick(1);
    end
    check("capture spacing", (three ? t3_reload : t2_reload) - first, 16'h007C);
  endtask : t_cap
  // With both capture modes off the running oscillator must neither pulse nor touch the reloads.
  task automatic t_nocap();
    int n;
    logic [15:0] held2;
    logic [15:0] held3;
    t2_capture_mode = 1'b0;
    t3_capture_mode = 1'b0;
    held2 = t2_reload;
    held3 = t3_reload;
    n = 0;
    repeat (300) begin
      tick(1);
      if (t2_capture !== 1'b0 || t3_capture !== 1'b0) n++;
    end
    check("captures with mode off", n[15:0], 16'h0000);
    check("t2 reload held", t2_reload, held2);
    check("t3 reload held", t3_reload, held3);
  endtask : t_nocap
  initial begin
    tick(16);
    reset = 1'b0;
    tick(2);
    t_reset();
    t_ready();
    t_div();
    t_stop();
    t_cap(1'b0);
    t_cap(1'b1);
    t_nocap();
    print_verdict();
  end
  // Watchdog well past the expected run of about half a millisecond.
  initial begin
    #5000000;
    num_errors++;
    print_verdict();
  end
endmodule : lfoc_top_test
